//--- verilog/sbc_seq_pkg.sv
`default_nettype none
package sbc_seq_pkg;

    // ------------------------------------------------------------
    // time base
    // ------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ    = 50_000_000;
    localparam int unsigned TICK_PERIOD_US = 1000;
    localparam int unsigned TICK_CYCLES    = CLK_FREQ_HZ / 1_000_000 * TICK_PERIOD_US;

    // ------------------------------------------------------------
    // sequence times, in time base ticks (milliseconds)
    // ------------------------------------------------------------
    localparam int unsigned FIRST_WRITE_TIMEOUT_MS = 350;
    localparam int unsigned SLEEP_RESET_MS         = 100;
    localparam int unsigned WD_RESET_PULSE_MS      = 1;
    localparam int unsigned MS_COUNT_W             = 9;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [MS_COUNT_W-1:0] MS_COUNT_RST = 9'h000;
    localparam logic [2:0]            MODE_RST     = 3'h0;

    // ------------------------------------------------------------
    // operating modes
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        normal_request_st,
        normal_st,
        wd_reset_st,
        uv_stop_reset_st,
        uv_sleep_reset_st,
        sleep_st
    } mode_t;

endpackage
`default_nettype wire

//--- verilog/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    input  wire logic d_i,
    output logic      q_o
);

    // ------------------------------------------------------------
    // two flip-flop synchroniser
    // ------------------------------------------------------------
    logic meta;

    // first stage is read only by the second
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= 1'b0;
            q_o  <= 1'b0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule
`default_nettype wire

//--- verilog/ms_time_base.sv
`timescale 1ns/1ps
`default_nettype none
module ms_time_base #(
    parameter int unsigned CYCLES = 50_000
) (
    input  wire logic clk_i,
    input  wire logic nrst_i,
    output logic      tick_o
);

    // ------------------------------------------------------------
    // divider making a one-cycle tick per period
    // ------------------------------------------------------------
    logic [31:0] div;

    // counts down, tick on wrap
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div    <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (div == 32'h0000_0000) begin
            div    <= 32'(CYCLES - 1);
            tick_o <= 1'b1;
        end else begin
            div    <= div - 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- verilog/sbc_powerup_fault_sequencer.sv
// Function
// - power-up: normal-request, main on, second off, transceiver on
// - no period write in 350 ms: reset, back
// - watchdog status low through first-write timeout cycle
// - period write: normal mode, second regulator on
// - normal mode: watchdog status high, reset high
// - missed refresh: reset, back to normal-request
// - stop selected, under-voltage: reset mode, reset asserted
// - stop under-voltage: interrupt low, watchdog status high
// - under-voltage cleared after stop reset: normal-request
// - sleep selected, flag cleared, under-voltage: 100 ms reset
// - sleep under-voltage: reset, interrupt low, status high
// - after 100 ms: sleep, both regulators off
`timescale 1ns/1ps
`default_nettype none
module sbc_powerup_fault_sequencer
    import sbc_seq_pkg::*;
#(
    parameter int unsigned TICK_DIV = sbc_seq_pkg::TICK_CYCLES
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       wd_period_write_i,
    input  wire logic       wd_refresh_missed_i,
    input  wire logic       lp_sleep_select_i,
    input  wire logic       battery_fail_flag_i,
    input  wire logic       main_reg_uv_i,
    output logic            rst_n_o,
    output logic            int_n_o,
    output logic            watchdog_status_pin_n_o,
    output logic            main_reg_en_o,
    output logic            second_regulator_en_o,
    output logic            transceiver_transmit_receive_o,
    output logic [2:0]      mode_o
);

    import sbc_seq_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    mode_t                  state;
    mode_t                  next_state;
    logic                   tick;
    logic                   uv;
    logic [MS_COUNT_W-1:0]  ms_count;
    logic [MS_COUNT_W-1:0]  next_ms_count;
    logic                   entering;
    logic                   first_write_timeout;
    logic                   sleep_reset_done;
    logic                   wd_pulse_done;
    logic                   uv_to_sleep;

    localparam logic [MS_COUNT_W-1:0] FIRST_WRITE_LAST =
        MS_COUNT_W'(FIRST_WRITE_TIMEOUT_MS - 1);
    localparam logic [MS_COUNT_W-1:0] SLEEP_RESET_LAST =
        MS_COUNT_W'(SLEEP_RESET_MS - 1);
    localparam logic [MS_COUNT_W-1:0] WD_PULSE_LAST =
        MS_COUNT_W'(WD_RESET_PULSE_MS - 1);

    // ------------------------------------------------------------
    // time base and input synchroniser
    // ------------------------------------------------------------

    // one tick per millisecond
    ms_time_base #(
        .CYCLES (TICK_DIV)
    ) u_time_base (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .tick_o (tick)
    );

    // comparator output arrives from the analog side
    sync2 u_uv_sync (
        .clk_i  (clk_i),
        .nrst_i (nrst_i),
        .d_i    (main_reg_uv_i),
        .q_o    (uv)
    );

    // ------------------------------------------------------------
    // timeout decode
    // ------------------------------------------------------------

    // expiry on the tick that ends the last millisecond
    assign first_write_timeout = tick && (ms_count == FIRST_WRITE_LAST);
    assign sleep_reset_done    = tick && (ms_count == SLEEP_RESET_LAST);
    // watchdog reset pulse ends on the first tick after entry
    assign wd_pulse_done       = tick && (ms_count == WD_PULSE_LAST);

    // sleep path needs sleep selected and the flag cleared
    assign uv_to_sleep = lp_sleep_select_i && !battery_fail_flag_i;

    // ------------------------------------------------------------
    // next mode
    // ------------------------------------------------------------

    // under-voltage takes priority over watchdog events
    always_comb begin
        next_state = state;
        case (state)
            normal_request_st: begin
                if (uv) begin
                    if (uv_to_sleep) begin
                        next_state = uv_sleep_reset_st;
                    end else begin
                        next_state = uv_stop_reset_st;
                    end
                end else if (wd_period_write_i) begin
                    next_state = normal_st;
                end else if (first_write_timeout) begin
                    next_state = wd_reset_st;
                end
            end
            normal_st: begin
                if (uv) begin
                    if (uv_to_sleep) begin
                        next_state = uv_sleep_reset_st;
                    end else begin
                        next_state = uv_stop_reset_st;
                    end
                end else if (wd_refresh_missed_i) begin
                    next_state = wd_reset_st;
                end
            end
            wd_reset_st: begin
                if (uv) begin
                    if (uv_to_sleep) begin
                        next_state = uv_sleep_reset_st;
                    end else begin
                        next_state = uv_stop_reset_st;
                    end
                end else if (wd_pulse_done) begin
                    next_state = normal_request_st;
                end
            end
            uv_stop_reset_st: begin
                if (!uv) begin
                    next_state = normal_request_st;
                end
            end
            uv_sleep_reset_st: begin
                if (sleep_reset_done) begin
                    next_state = sleep_st;
                end
            end
            sleep_st: begin
                // only nrst_i leaves sleep
                next_state = sleep_st;
            end
            default: begin
                next_state = normal_request_st;
            end
        endcase
    end

    // ------------------------------------------------------------
    // millisecond counter
    // ------------------------------------------------------------

    // restart on every mode change
    // free-runs in untimed modes, where its value is unused
    assign entering = (next_state != state);

    always_comb begin
        next_ms_count = ms_count;
        if (entering) begin
            next_ms_count = MS_COUNT_RST;
        end else if (tick) begin
            next_ms_count = ms_count + MS_COUNT_W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ms_count <= MS_COUNT_RST;
        end else begin
            ms_count <= next_ms_count;
        end
    end

    // ------------------------------------------------------------
    // mode register
    // ------------------------------------------------------------

    // power-up lands in normal-request
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= normal_request_st;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // output flops, decoded from the next mode
    // ------------------------------------------------------------

    // reset output, low in every reset mode and in sleep
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_n_o <= 1'b1;
        end else begin
            case (next_state)
                wd_reset_st:       rst_n_o <= 1'b0;
                uv_stop_reset_st:  rst_n_o <= 1'b0;
                uv_sleep_reset_st: rst_n_o <= 1'b0;
                sleep_st:          rst_n_o <= 1'b0;
                normal_st:         rst_n_o <= 1'b1;
                default:           rst_n_o <= 1'b1;
            endcase
        end
    end

    // interrupt output, low during under-voltage resets
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            int_n_o <= 1'b1;
        end else begin
            case (next_state)
                uv_stop_reset_st:  int_n_o <= 1'b0;
                uv_sleep_reset_st: int_n_o <= 1'b0;
                normal_st:         int_n_o <= 1'b1;
                sleep_st:          int_n_o <= 1'b1;
                default:           int_n_o <= 1'b1;
            endcase
        end
    end

    // watchdog status, active low in normal-request and watchdog reset
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            watchdog_status_pin_n_o <= 1'b0;
        end else begin
            case (next_state)
                normal_request_st: watchdog_status_pin_n_o <= 1'b0;
                wd_reset_st:       watchdog_status_pin_n_o <= 1'b0;
                normal_st:         watchdog_status_pin_n_o <= 1'b1;
                uv_stop_reset_st:  watchdog_status_pin_n_o <= 1'b1;
                uv_sleep_reset_st: watchdog_status_pin_n_o <= 1'b1;
                sleep_st:          watchdog_status_pin_n_o <= 1'b1;
                default:           watchdog_status_pin_n_o <= 1'b1;
            endcase
        end
    end

    // main regulator, off only in sleep
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            main_reg_en_o <= 1'b1;
        end else begin
            case (next_state)
                sleep_st: main_reg_en_o <= 1'b0;
                normal_st: main_reg_en_o <= 1'b1;
                default:  main_reg_en_o <= 1'b1;
            endcase
        end
    end

    // second regulator, on only in normal mode
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            second_regulator_en_o <= 1'b0;
        end else begin
            case (next_state)
                normal_st:         second_regulator_en_o <= 1'b1;
                uv_stop_reset_st:  second_regulator_en_o <= 1'b0;
                uv_sleep_reset_st: second_regulator_en_o <= 1'b0;
                sleep_st:          second_regulator_en_o <= 1'b0;
                default:           second_regulator_en_o <= 1'b0;
            endcase
        end
    end

    // transceiver active in the two awake modes
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            transceiver_transmit_receive_o <= 1'b1;
        end else begin
            case (next_state)
                normal_request_st: transceiver_transmit_receive_o <= 1'b1;
                normal_st:         transceiver_transmit_receive_o <= 1'b1;
                wd_reset_st:       transceiver_transmit_receive_o <= 1'b0;
                sleep_st:          transceiver_transmit_receive_o <= 1'b0;
                default:           transceiver_transmit_receive_o <= 1'b0;
            endcase
        end
    end

    // mode readback
    // codes follow the enum order, normal-request first
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_o <= MODE_RST;
        end else begin
            mode_o <= 3'(next_state);
        end
    end

endmodule
`default_nettype wire

//--- tb/sbc_seq_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_seq_asserts #(
    parameter int unsigned TICK_DIV = 4
) (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic       wd_period_write_i,
    input wire logic       wd_refresh_missed_i,
    input wire logic       lp_sleep_select_i,
    input wire logic       battery_fail_flag_i,
    input wire logic       main_reg_uv_i,
    input wire logic       rst_n_o,
    input wire logic       int_n_o,
    input wire logic       watchdog_status_pin_n_o,
    input wire logic       main_reg_en_o,
    input wire logic       second_regulator_en_o,
    input wire logic       transceiver_transmit_receive_o,
    input wire logic [2:0] mode_o
);
    localparam int BACK_MAX = 2 * TICK_DIV;
    logic [15:0] dwell;
    logic [1:0]  uv_hist;
    logic        quiet;
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    // cycles spent in sleep-entry reset, and recent under-voltage samples
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dwell <= 16'h0000;
            uv_hist <= 2'h0;
        end else begin
            dwell <= (mode_o == 3'h4) ? dwell + 16'h0001 : 16'h0000;
            uv_hist <= {uv_hist[0], main_reg_uv_i};
        end
    end
    assign quiet = ~main_reg_uv_i & ~|uv_hist; // no under-voltage in flight
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    nreq_outputs_a: assert property (mode_o == 3'h0 |-> main_reg_en_o && rst_n_o
        && !second_regulator_en_o && transceiver_transmit_receive_o)
        else $error("normal-request outputs wrong");
    status_low_a: assert property (mode_o inside {3'h0, 3'h2}
        |-> !watchdog_status_pin_n_o) else $error("watchdog status not low");
    write_normal_a: assert property (mode_o == 3'h0 && wd_period_write_i && quiet
        |=> mode_o == 3'h1 && second_regulator_en_o) else $error("write did not enter normal");
    normal_out_a: assert property (mode_o == 3'h1 |-> watchdog_status_pin_n_o && rst_n_o)
        else $error("normal mode outputs wrong");
    miss_reset_a: assert property (mode_o == 3'h1 && wd_refresh_missed_i && quiet
        |=> mode_o == 3'h2 && !rst_n_o) else $error("missed refresh gave no reset");
    wd_return_a: assert property ($rose(mode_o == 3'h2)
        |-> ##[1:BACK_MAX] mode_o == 3'h0) else $error("no return after watchdog reset");
    uv_entry_a: assert property (mode_o inside {3'h0, 3'h1} && main_reg_uv_i
        |-> ##[1:4] mode_o inside {3'h3, 3'h4}) else $error("under-voltage not taken");
    stop_path_a: assert property ($rose(mode_o == 3'h3)
        |-> !($past(lp_sleep_select_i) && !$past(battery_fail_flag_i)))
        else $error("stop reset taken on sleep path");
    sleep_path_a: assert property ($rose(mode_o == 3'h4)
        |-> $past(lp_sleep_select_i) && !$past(battery_fail_flag_i))
        else $error("sleep reset taken on stop path");
    stop_uv_a: assert property (mode_o == 3'h3 |-> !rst_n_o && !int_n_o
        && watchdog_status_pin_n_o) else $error("stop reset outputs wrong");
    sleep_uv_a: assert property (mode_o == 3'h4 |-> !rst_n_o && !int_n_o
        && watchdog_status_pin_n_o) else $error("sleep reset outputs wrong");
    sleep_len_a: assert property ($past(mode_o) == 3'h4 && mode_o != 3'h4
        |-> mode_o == 3'h5
        && $past(dwell) >= 99 * TICK_DIV - 2 && $past(dwell) <= 100 * TICK_DIV + 1)
        else $error("sleep-entry reset length wrong");
    sleep_off_a: assert property (mode_o == 3'h5
        |-> !main_reg_en_o && !second_regulator_en_o) else $error("regulators on in sleep");
    cover property (mode_o == 3'h1);
    cover property (mode_o == 3'h3);
    cover property (mode_o == 3'h5);
endmodule
bind sbc_powerup_fault_sequencer sbc_seq_asserts #(.TICK_DIV(TICK_DIV)) sbc_seq_asserts_inst (
    .clk_i(clk_i), .nrst_i(nrst_i), .wd_period_write_i(wd_period_write_i),
    .wd_refresh_missed_i(wd_refresh_missed_i), .main_reg_uv_i(main_reg_uv_i),
    .lp_sleep_select_i(lp_sleep_select_i), .battery_fail_flag_i(battery_fail_flag_i),
    .rst_n_o(rst_n_o), .int_n_o(int_n_o), .watchdog_status_pin_n_o(watchdog_status_pin_n_o),
    .main_reg_en_o(main_reg_en_o), .second_regulator_en_o(second_regulator_en_o),
    .transceiver_transmit_receive_o(transceiver_transmit_receive_o), .mode_o(mode_o));
`default_nettype wire

//--- tb/host_mcu_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_mcu_model (
    input  wire logic clk_i,
    output var logic  wd_period_write_o,
    output var logic  wd_refresh_missed_o
);
    initial begin
        wd_period_write_o = 1'b0;
        wd_refresh_missed_o = 1'b0;
    end
    // one-cycle period write after a chosen delay
    task automatic write_period(input int delay);
        repeat (delay + 1) @(posedge clk_i);
        wd_period_write_o <= 1'b1;
        @(posedge clk_i);
        wd_period_write_o <= 1'b0;
    endtask
    // one-cycle missed refresh after a chosen delay
    task automatic miss_refresh(input int delay);
        repeat (delay + 1) @(posedge clk_i);
        wd_refresh_missed_o <= 1'b1;
        @(posedge clk_i);
        wd_refresh_missed_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb/sbc_powerup_fault_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sbc_powerup_fault_sequencer_bench;
    import sbc_seq_pkg::*;
    localparam int TD = 4;
    logic       clk_i, nrst_i, sel, flag, uv, wr, miss;
    logic       rst_n, int_n, st_n, main_en, sec_en, transceiver_transmit_receive;
    logic [2:0] mode;
    int         bad_count = 0;
    int         n_checks = 0;
    int         cycles = 0;
    sbc_powerup_fault_sequencer #(.TICK_DIV(TD)) sbc_powerup_fault_sequencer_inst (
        .clk_i(clk_i), .nrst_i(nrst_i), .wd_period_write_i(wr), .wd_refresh_missed_i(miss),
        .lp_sleep_select_i(sel), .battery_fail_flag_i(flag), .main_reg_uv_i(uv),
        .rst_n_o(rst_n), .int_n_o(int_n), .watchdog_status_pin_n_o(st_n),
        .main_reg_en_o(main_en), .second_regulator_en_o(sec_en),
        .transceiver_transmit_receive_o(transceiver_transmit_receive), .mode_o(mode));
    host_mcu_model host_mcu_model_inst (
        .clk_i(clk_i), .wd_period_write_o(wr), .wd_refresh_missed_o(miss));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_mode(input logic [2:0] m, output int cnt);
        cnt = 0;
        while (mode !== m && cnt < 5000) begin
            step(1);
            cnt++;
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic test_powerup();
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (10) @(posedge clk_i);
        nrst_i <= 1'b1;
        #1;
        check("mode", mode, normal_request_st);
        check("regs", {main_en, sec_en, transceiver_transmit_receive, rst_n}, 4'hb);
        check("status_n", st_n, 1'b0);
        $display("test powerup done");
    endtask
    task automatic test_first_timeout();
        int cnt;
        for (int i = 0; i < 2; i++) begin
            wait_mode(wd_reset_st, cnt);
            check("timeout", cnt >= 348 * TD && cnt <= 351 * TD, 1'b1);
            check("rst_n", rst_n, 1'b0);
            check("status_n", st_n, 1'b0);
            check("transceiver_transmit_receive", transceiver_transmit_receive, 1'b0);
            wait_mode(normal_request_st, cnt);
            check("back", cnt <= 2 * TD, 1'b1);
            check("status_n", st_n, 1'b0);
        end
        $display("test first_timeout done");
    endtask
    task automatic test_write_miss();
        int cnt;
        host_mcu_model_inst.miss_refresh(0);
        #1;
        check("mode", mode, normal_request_st);
        host_mcu_model_inst.write_period(3);
        #1;
        check("mode", mode, normal_st);
        check("regs", {main_en, sec_en, st_n, rst_n}, 4'hf);
        host_mcu_model_inst.write_period(0);
        #1;
        check("mode", mode, normal_st);
        host_mcu_model_inst.miss_refresh(0);
        #1;
        check("mode", mode, wd_reset_st);
        check("rst_n", rst_n, 1'b0);
        wait_mode(normal_request_st, cnt);
        check("sec_en", sec_en, 1'b0);
        $display("test write_miss done");
    endtask
    task automatic test_stop_uv(input logic s, input logic f);
        int cnt;
        host_mcu_model_inst.write_period(0);
        @(posedge clk_i);
        sel <= s;
        flag <= f;
        uv <= 1'b1;
        step(3);
        check("mode", mode, uv_stop_reset_st);
        check("pins", {rst_n, int_n, st_n, transceiver_transmit_receive, sec_en}, 5'h04);
        @(posedge clk_i);
        uv <= 1'b0;
        wait_mode(normal_request_st, cnt);
        check("restart", cnt <= 4, 1'b1);
        $display("test stop_uv done");
    endtask
    task automatic test_sleep_uv();
        int cnt;
        host_mcu_model_inst.write_period(0);
        @(posedge clk_i);
        sel <= 1'b1;
        flag <= 1'b0;
        uv <= 1'b1;
        step(3);
        check("mode", mode, uv_sleep_reset_st);
        check("pins", {rst_n, int_n, st_n}, 3'h1);
        wait_mode(sleep_st, cnt);
        check("dwell", cnt >= 99 * TD - 4 && cnt <= 100 * TD + 2, 1'b1);
        check("regs", {main_en, sec_en, rst_n, int_n, transceiver_transmit_receive}, 5'h02);
        @(posedge clk_i);
        uv <= 1'b0;
        step(10);
        check("mode", mode, sleep_st);
        $display("test sleep_uv done");
    endtask
    // ------------------------------------------------------------
    // clock, watchdog on the run, main sequence
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    initial begin
        nrst_i = 1'b0;
        sel = 1'b0;
        flag = 1'b0;
        uv = 1'b0;
        test_powerup();
        test_first_timeout();
        test_write_miss();
        test_stop_uv(1'b0, 1'b0);
        test_stop_uv(1'b0, 1'b1);
        test_stop_uv(1'b1, 1'b1);
        test_sleep_uv();
        test_powerup();
        end_of_test();
    end
endmodule
`default_nettype wire
